// ==== verilog/disk_data_separator_interface.sv ====
// Data separator: AXI4-Lite control, read recovery and write conditioning
`timescale 1ns/1ps

// Functional notes
// - Read data is regenerated raw pulses, aligned to recovered clock.
// - Recovered clock is half the oscillator rate, reference or data locked.
// - Sync detect rises on short pulse periods, falls on long ones.
// - Window offset shifts detection late when high, early when low, none floating.
// - Incoming write stream is conditioned and driven on precomp write output.
// - Active-low advance input emits current write bit early.
// - Active-low delay input emits current write bit late, unless advance is also low.
// - Advance and delay act only while precomp enable is high.
// - Precomp write output is low whenever write gate is low.
// - Write clock toggles at half the reference rate.
// - Code-rate select high picks (2,7) RLL, low picks (1,3) MFM.
// - Seek done low keeps the oscillator on the reference.
// - Zero-phase startup clamps the tank node high, then releases it.
// - Velocity lock six byte times, then phase lock, sync detector sleeps.
// - Clamp lasts at least one data period on each read mode change.
// - Velocity lock divides oscillator by two in MFM, three in RLL.
module disk_data_separator_interface
	import dsep_pkg::*;
#(
	parameter int SYNC_THR_MFM = 4,
	parameter int SYNC_THR_RLL = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic link_clk,
	input wire logic drive_read_pulses,
	input wire logic write_data_in,
	input wire logic advance_n,
	input wire logic retard_n,
	output logic read_data_out,
	output logic recovered_clk_out,
	output logic sync_field_detect,
	output logic precomp_write_out,
	output logic write_clk_out,
	output logic pfd_feed_out,
	input wire logic osc_tank_in,
	output logic osc_tank_out,
	output logic osc_tank_oe
);
	// ==================================================
	// AXI4-Lite slave, bus clock domain
	ctrl_t ctrl_r;
	logic aw_got_r, w_got_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	status_t stat_m_r, stat_s_r;

	function automatic logic [1:0] decode_resp(input logic [7:0] a);
		decode_resp = (a == CTRL_ADDR || a == STATUS_ADDR) ? RESP_OKAY : RESP_SLVERR;
	endfunction

	// Address and data taken in either order, one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (aw_got_r && w_got_r && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= decode_resp(awaddr_r);
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Ready only while the slot is empty, so back-pressure is honest
	always_comb begin
		s_axi_awready = !aw_got_r && !s_axi_bvalid;
		s_axi_wready = !w_got_r && !s_axi_bvalid;
	end

	// Control register; only the low byte lane carries bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= CTRL_RST;
		end else if (ce && aw_got_r && w_got_r && !s_axi_bvalid
			&& awaddr_r == CTRL_ADDR && wstrb_r[0]) begin
			ctrl_r <= wdata_r[6:0];
		end
	end

	// Read channel, answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= decode_resp(s_axi_araddr);
				if (s_axi_araddr == CTRL_ADDR) begin
					s_axi_rdata <= {25'h0000000, ctrl_r};
				end else if (s_axi_araddr == STATUS_ADDR) begin
					s_axi_rdata <= {26'h0000000, stat_s_r};
				end else begin
					s_axi_rdata <= 32'h0000_0000;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		s_axi_arready = !s_axi_rvalid;
	end

	// ==================================================
	// Crossings between the two clocks
	// Control bits are quasi-static levels, so a per-bit 2FF is enough
	ctrl_t ctrl_m_r, ctrl_l_r;
	logic rst_m_r, link_rst_n;
	logic ce_m_r, ce_l;
	logic [2:0] pin_m_r, pin_s_r;
	logic osc_m_r, osc_s_r;
	status_t stat_l_r;

	always_ff @(posedge link_clk) begin
		rst_m_r <= aresetn;
		link_rst_n <= rst_m_r;
		ce_m_r <= ce;
		ce_l <= ce_m_r;
		ctrl_m_r <= ctrl_r;
		ctrl_l_r <= ctrl_m_r;
		pin_m_r <= {drive_read_pulses, write_data_in, 1'b0};
		pin_s_r <= pin_m_r;
		osc_m_r <= osc_tank_in;
		osc_s_r <= osc_m_r;
	end

	// Status back into the bus domain
	always_ff @(posedge aclk) begin
		stat_m_r <= stat_l_r;
		stat_s_r <= stat_m_r;
	end

	// Advance and delay are sampled with the write bit, two stages like data
	logic [1:0] pc_m_r, pc_s_r;
	always_ff @(posedge link_clk) begin
		pc_m_r <= {advance_n, retard_n};
		pc_s_r <= pc_m_r;
	end

	// ==================================================
	// Acquisition sequencer, link clock domain
	seq_state_t st_r;
	logic [7:0] tmr_r;
	logic rd_req, wr_req;

	// Write wins when both gates are up; seek done gates reading
	always_comb begin
		wr_req = ctrl_l_r.write_window_gate;
		rd_req = ctrl_l_r.read_window_gate && ctrl_l_r.seek_done && !wr_req;
	end

	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			st_r <= S_IDLE;
			tmr_r <= 8'h00;
		end else if (ce_l) begin
			if (tmr_r != 8'h00) begin
				tmr_r <= tmr_r - 8'h01;
			end
			case (st_r)
				S_IDLE: begin
					if (wr_req) begin
						st_r <= S_WRITE;
					end else if (rd_req) begin
						st_r <= S_CLAMP_RD;
						tmr_r <= 8'(CLAMP_CYC - 1);
					end
				end
				S_CLAMP_RD: begin
					if (tmr_r == 8'h00) begin
						st_r <= S_VEL;
						tmr_r <= 8'(VEL_CYC - 1);
					end
				end
				S_VEL, S_PHASE: begin
					if (!rd_req) begin
						st_r <= S_CLAMP_IDLE;
						tmr_r <= 8'(CLAMP_CYC - 1);
					end else if (st_r == S_VEL && tmr_r == 8'h00) begin
						st_r <= S_PHASE;
					end
				end
				S_CLAMP_IDLE: begin
					if (tmr_r == 8'h00) begin
						st_r <= S_IDLE;
					end
				end
				S_WRITE: begin
					if (!wr_req) begin
						st_r <= S_IDLE;
					end
				end
				default: begin
					st_r <= S_IDLE;
				end
			endcase
		end
	end

	// Zero-phase clamp: drive tank node high while clamping
	logic clamp_w;
	assign clamp_w = (st_r == S_CLAMP_RD) || (st_r == S_CLAMP_IDLE);
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			osc_tank_oe <= 1'b0;
			osc_tank_out <= 1'b0;
		end else if (ce_l) begin
			osc_tank_oe <= clamp_w;
			osc_tank_out <= clamp_w;
		end
	end

	// ==================================================
	// Clocks: write clock and recovered clock at half rate
	logic in_read;
	assign in_read = (st_r == S_VEL) || (st_r == S_PHASE);
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			write_clk_out <= 1'b0;
			recovered_clk_out <= 1'b0;
		end else if (ce_l) begin
			write_clk_out <= !write_clk_out;
			// half rate, restarts from known phase after clamp
			recovered_clk_out <= clamp_w ? 1'b0 : !recovered_clk_out;
		end
	end

	// Frequency detector feed: divided in velocity lock, raw in phase lock
	logic [1:0] div_r;
	logic [1:0] div_top;
	assign div_top = ctrl_l_r.code_rate_select ? 2'(VEL_DIV_RLL - 1) : 2'(VEL_DIV_MFM - 1);
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			div_r <= 2'h0;
			pfd_feed_out <= 1'b0;
		end else if (ce_l) begin
			if (st_r == S_PHASE) begin
				div_r <= 2'h0;
				pfd_feed_out <= 1'b1;
			end else begin
				div_r <= (div_r >= div_top) ? 2'h0 : div_r + 2'h1;
				pfd_feed_out <= (div_r == 2'h0);
			end
		end
	end

	// ==================================================
	// Read path: edge detect, window shift, clock alignment
	logic raw_d_r, raw_edge;
	logic [2:0] rtap_r;
	logic pend_r;
	logic [1:0] rsel;
	assign raw_edge = pin_s_r[2] && !raw_d_r;

	always_comb begin
		case (ctrl_l_r.window_offset_select)
			WOFS_LATE: rsel = TAP_LATE;
			WOFS_EARLY: rsel = TAP_EARLY;
			default: rsel = TAP_NOM;
		endcase
	end

	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			raw_d_r <= 1'b1; // Idle level of the pulled-up pin, no false edge
			rtap_r <= 3'h0;
			pend_r <= 1'b0;
			read_data_out <= 1'b0;
		end else if (ce_l) begin
			raw_d_r <= pin_s_r[2];
			rtap_r <= {rtap_r[1:0], raw_edge && in_read};
			// emit with recovered clock rising
			// Emit only while read stays up, so no pulse leaks past a gate drop
			if (!recovered_clk_out && in_read && rd_req) begin
				read_data_out <= pend_r || rtap_r[rsel];
				pend_r <= 1'b0;
			end else begin
				read_data_out <= 1'b0;
				pend_r <= in_read && (pend_r || rtap_r[rsel]);
			end
		end
	end

	// Sync field detector: period between rising edges versus threshold
	logic [3:0] per_r;
	logic [3:0] thr;
	logic sleep_w;
	assign thr = ctrl_l_r.code_rate_select ? 4'(SYNC_THR_RLL) : 4'(SYNC_THR_MFM);
	// detector asleep in phase lock and write
	assign sleep_w = (st_r == S_PHASE) || (st_r == S_WRITE);
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			per_r <= 4'h0;
			sync_field_detect <= 1'b0;
		end else if (ce_l && !sleep_w) begin
			if (raw_edge) begin
				per_r <= 4'h0;
				sync_field_detect <= (per_r < thr);
			end else if (per_r >= thr) begin
				sync_field_detect <= 1'b0;
			end else begin
				per_r <= per_r + 4'h1;
			end
		end
	end

	// ==================================================
	// Write path: clocked data, three-tap precomp, gate forcing low
	logic wr_d_r, wr_edge;
	logic [2:0] wtap_r;
	logic [1:0] wsel_r;
	assign wr_edge = pin_s_r[1] && !wr_d_r;

	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			wr_d_r <= 1'b1; // Write data pin idles high on its pull-up
			wtap_r <= 3'h0;
			wsel_r <= TAP_NOM;
			precomp_write_out <= 1'b0;
		end else if (ce_l) begin
			wr_d_r <= pin_s_r[1];
			wtap_r <= {wtap_r[1:0], wr_edge};
			if (wr_edge) begin
				if (!ctrl_l_r.precomp_enable) begin
					wsel_r <= TAP_NOM;
				end else if (!pc_s_r[1]) begin
					wsel_r <= TAP_EARLY;
				end else if (!pc_s_r[0]) begin
					wsel_r <= TAP_LATE;
				end else begin
					wsel_r <= TAP_NOM;
				end
			end
			precomp_write_out <= wr_req && (st_r == S_WRITE) && wtap_r[wsel_r];
		end
	end

	// Status gathered on the link clock before crossing
	always_ff @(posedge link_clk) begin
		stat_l_r <= {osc_s_r, clamp_w, st_r == S_PHASE, st_r == S_VEL,
			st_r == S_WRITE, sync_field_detect};
	end

	// ==================================================
	// Assertions
	property p_gate_low_out;
		@(posedge link_clk) disable iff (!link_rst_n)
		!wr_req |=> !precomp_write_out;
	endproperty
	a_gate_low_out: assert property (p_gate_low_out) else $error("write out high without gate");

	// The release edge still resets the flop, so it starts no attempt
	property p_wclk_half;
		@(posedge link_clk) disable iff (!link_rst_n)
		(link_rst_n && ce_l) |=> write_clk_out != $past(write_clk_out);
	endproperty
	a_wclk_half: assert property (p_wclk_half) else $error("write clock missed toggle");

	// Helper count of velocity lock cycles, too long for a repetition
	logic [7:0] vel_cnt_r;
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			vel_cnt_r <= 8'h00;
		end else if (ce_l) begin
			vel_cnt_r <= (st_r == S_VEL) ? vel_cnt_r + 8'h01 : 8'h00;
		end
	end

	property p_vel_to_phase;
		@(posedge link_clk) disable iff (!link_rst_n)
		($fell(st_r == S_VEL) && st_r == S_PHASE) |-> vel_cnt_r == 8'(VEL_CYC);
	endproperty
	a_vel_to_phase: assert property (p_vel_to_phase) else $error("velocity lock too short");

	property p_clamp_min;
		@(posedge link_clk) disable iff (!link_rst_n)
		$rose(osc_tank_oe) |-> osc_tank_oe[*2] ##0 osc_tank_out;
	endproperty
	a_clamp_min: assert property (p_clamp_min) else $error("clamp shorter than a period");

	property p_seek_hold;
		@(posedge link_clk) disable iff (!link_rst_n)
		(st_r == S_IDLE && !ctrl_l_r.seek_done) |=> st_r != S_CLAMP_RD;
	endproperty
	a_seek_hold: assert property (p_seek_hold) else $error("read entered without seek done");

	property p_write_prio;
		@(posedge link_clk) disable iff (!link_rst_n)
		(ce_l && st_r == S_IDLE && ctrl_l_r.write_window_gate) |=> st_r == S_WRITE;
	endproperty
	a_write_prio: assert property (p_write_prio) else $error("write gate not obeyed");

	property p_nominal_off;
		@(posedge link_clk) disable iff (!link_rst_n)
		(ce_l && wr_edge && !ctrl_l_r.precomp_enable) |=> wsel_r == TAP_NOM;
	endproperty
	a_nominal_off: assert property (p_nominal_off) else $error("precomp used while disabled");

	property p_rdata_align;
		@(posedge link_clk) disable iff (!link_rst_n)
		read_data_out |-> recovered_clk_out && in_read;
	endproperty
	a_rdata_align: assert property (p_rdata_align) else $error("read data not on clock rise");

	property p_sync_long;
		@(posedge link_clk) disable iff (!link_rst_n)
		(ce_l && !sleep_w && !raw_edge && per_r >= thr) |=> !sync_field_detect;
	endproperty
	a_sync_long: assert property (p_sync_long) else $error("sync detect high on long period");

	property p_rclk_restart;
		@(posedge link_clk) disable iff (!link_rst_n)
		$fell(clamp_w) |-> !recovered_clk_out;
	endproperty
	a_rclk_restart: assert property (p_rclk_restart) else $error("clock not restarted in phase");

	c_read_entry: cover property (@(posedge link_clk) $rose(st_r == S_CLAMP_RD));
	c_phase_lock: cover property (@(posedge link_clk) $rose(st_r == S_PHASE));
	c_write_pulse: cover property (@(posedge link_clk) $rose(precomp_write_out));
	c_sync_high: cover property (@(posedge link_clk) $rose(sync_field_detect));
endmodule

// ==== verilog/dsep_pkg.sv ====
// Package: constants, register map and carrier types of the data separator
package dsep_pkg;
	// ==================================================
	// Register map (byte addresses)
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==================================================
	// Window offset encoding (three-level pin seen as two bits)
	localparam logic [1:0] WOFS_NONE = 2'h0;
	localparam logic [1:0] WOFS_LATE = 2'h1;
	localparam logic [1:0] WOFS_EARLY = 2'h2;

	// Delay line taps shared by read window shift and write precomp
	localparam logic [1:0] TAP_EARLY = 2'h0;
	localparam logic [1:0] TAP_NOM = 2'h1;
	localparam logic [1:0] TAP_LATE = 2'h2;

	// ==================================================
	// Timing, in link clock cycles
	localparam int DATA_PERIOD_CYC = 2;
	localparam int CLAMP_PERIODS = 3;
	localparam int CLAMP_CYC = CLAMP_PERIODS * DATA_PERIOD_CYC;
	localparam int VEL_BYTES = 6;
	localparam int BITS_PER_BYTE = 8;
	localparam int VEL_CYC = VEL_BYTES * BITS_PER_BYTE * DATA_PERIOD_CYC;
	localparam int VEL_DIV_MFM = 2;
	localparam int VEL_DIV_RLL = 3;

	// Control register, reset value keeps the loop on the reference
	typedef struct packed {
		logic [1:0] window_offset_select;
		logic seek_done;
		logic code_rate_select;
		logic precomp_enable;
		logic write_window_gate;
		logic read_window_gate;
	} ctrl_t;
	localparam ctrl_t CTRL_RST = 7'h00;

	// Status seen by software
	typedef struct packed {
		logic osc_tank_level;
		logic clamp_active;
		logic phase_lock;
		logic velocity_lock;
		logic write_mode;
		logic sync_field_detect;
	} status_t;

	// Acquisition sequencer states
	typedef enum logic [2:0] {
		S_IDLE,
		S_CLAMP_RD,
		S_VEL,
		S_PHASE,
		S_CLAMP_IDLE,
		S_WRITE
	} seq_state_t;
endpackage

// ==== bench/drive_model.sv ====
// Drive-side model: read pulse source and oscillator tank node
`timescale 1ns/1ps
module drive_model (
	input wire logic link_clk,
	input wire logic [3:0] period,
	input wire logic osc_tank_out,
	input wire logic osc_tank_oe,
	output logic drive_read_pulses,
	output logic osc_tank_in
);
	logic [3:0] cnt_r = 4'h0;
	logic ring_r = 1'b0;

	// ==================================================
	// Pulse source
	// Period counter; zero period means the drive is deselected
	always_ff @(posedge link_clk) begin
		cnt_r <= (cnt_r + 4'h1 >= period) ? 4'h0 : cnt_r + 4'h1;
	end
	// Released line floats high on its pull-up, a pulse is a low dip
	assign drive_read_pulses = (period != 4'h0 && cnt_r == 4'h0) ? 1'b0 : 1'b1;

	// ==================================================
	// Tank node
	// Free ringing keeps the unclamped node moving every cycle
	always_ff @(posedge link_clk) begin
		ring_r <= ~ring_r;
	end
	// Clamp wins over the ringing
	assign osc_tank_in = osc_tank_oe ? osc_tank_out : ring_r;
endmodule

// ==== bench/disk_data_separator_interface_tb_top.sv ====
// Self-checking bench of the data separator
`timescale 1ns/1ps
module disk_data_separator_interface_tb_top;
	import dsep_pkg::*;
	logic aclk, link_clk, aresetn, ce;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, v;
	logic [3:0] s_axi_wstrb, period;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic drive_read_pulses, write_data_in, advance_n, retard_n, read_data_out;
	logic recovered_clk_out, sync_field_detect, precomp_write_out, write_clk_out;
	logic pfd_feed_out, osc_tank_in, osc_tank_out, osc_tank_oe, pw, pr;
	int err_total, compares, n, m, pulses, bad, clamps, nom, lat;

	// ==================================================
	// Clocks: bus 4 ns, link 125 ns on an unrelated phase
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial begin
		link_clk = 1'b0;
		#37;
		forever #62.5 link_clk = ~link_clk;
	end

	disk_data_separator_interface dut (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .link_clk(link_clk),
		.drive_read_pulses(drive_read_pulses), .write_data_in(write_data_in),
		.advance_n(advance_n), .retard_n(retard_n), .read_data_out(read_data_out),
		.recovered_clk_out(recovered_clk_out), .sync_field_detect(sync_field_detect),
		.precomp_write_out(precomp_write_out), .write_clk_out(write_clk_out),
		.pfd_feed_out(pfd_feed_out), .osc_tank_in(osc_tank_in),
		.osc_tank_out(osc_tank_out), .osc_tank_oe(osc_tank_oe)
	);

	drive_model drive (
		.link_clk(link_clk), .period(period), .osc_tank_out(osc_tank_out),
		.osc_tank_oe(osc_tank_oe), .drive_read_pulses(drive_read_pulses),
		.osc_tank_in(osc_tank_in)
	);

	// ==================================================
	// Reporting
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic give_up();
		err_total++;
		$display("mismatch at %0t wait ran out", $time);
		results();
	endtask

	// Expected pfd pulses over a span outside phase lock
	function automatic int pfd_exp(input logic rll, input int span);
		return span / (rll ? VEL_DIV_RLL : VEL_DIV_MFM);
	endfunction

	// ==================================================
	// Register bus master; bready and rready stay high throughout
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] r);
		logic aw_ok, w_ok, b_ok;
		// Start right after a bus edge, whatever the caller waited on
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= wd;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (int i = 0; i < 64; i++) begin
			@(negedge aclk);
			aw_ok = s_axi_awvalid & s_axi_awready;
			w_ok = s_axi_wvalid & s_axi_wready;
			b_ok = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw_ok) s_axi_awvalid <= 1'b0;
			if (w_ok) s_axi_wvalid <= 1'b0;
			if (b_ok) return;
		end
		give_up();
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] r);
		logic ar_ok, r_ok;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (int i = 0; i < 64; i++) begin
			@(negedge aclk);
			ar_ok = s_axi_arvalid & s_axi_arready;
			r_ok = s_axi_rvalid;
			rd = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar_ok) s_axi_arvalid <= 1'b0;
			if (r_ok) return;
		end
		give_up();
	endtask
	// Control write, then let it cross into the link domain
	task automatic ctrl(input logic [31:0] c);
		axi_wr(CTRL_ADDR, c, rsp);
		repeat (8) @(posedge link_clk);
		@(posedge aclk);
	endtask

	// ==================================================
	// Link side helpers, outputs sampled on the falling link edge
	task automatic watch(input int cyc);
		repeat (cyc) begin
			@(negedge link_clk);
			if (read_data_out === 1'b1) pulses++;
			if (read_data_out === 1'b1 && recovered_clk_out !== 1'b1) bad++;
			if (osc_tank_oe === 1'b1) clamps++;
		end
	endtask
	task automatic clamp_check();
		int i;
		logic bad_c;
		bad_c = 1'b0;
		for (i = 0; i < 40 && osc_tank_oe !== 1'b1; i++) @(negedge link_clk);
		if (i == 40) give_up();
		for (i = 0; i < 40 && osc_tank_oe === 1'b1; i++) begin
			if (osc_tank_out !== 1'b1 || recovered_clk_out !== 1'b0) bad_c = 1'b1;
			@(negedge link_clk);
		end
		check(32'(i), 32'(CLAMP_CYC));
		check({31'h0, bad_c}, 32'h0);
		@(posedge aclk);
	endtask
	// One write bit as a rising edge; latency in link cycles, -1 if none
	task automatic wbit(input logic a_n, input logic r_n, output int l);
		@(posedge link_clk);
		advance_n <= a_n;
		retard_n <= r_n;
		write_data_in <= 1'b0;
		repeat (2) @(posedge link_clk);
		write_data_in <= 1'b1;
		l = -1;
		for (int i = 0; i < 16; i++) begin
			@(negedge link_clk);
			if (precomp_write_out === 1'b1 && l < 0) l = i;
		end
	endtask

	// ==================================================
	// Main sequence
	initial begin
		{ce, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7F;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, period} = 52'h0;
		{write_data_in, advance_n, retard_n} = 3'h7;
		{err_total, compares} = 64'h0;
		v = $urandom(72035);
		// Long enough for the link side synchroniser too
		repeat (100) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(CTRL_ADDR, d, rsp);
		check(d, 32'h0);
		axi_rd(8'h08, d, rsp);
		check(d, 32'h0);
		check(32'(rsp), 32'(RESP_SLVERR));
		for (int k = 0; k < 6; k++) begin
			v = $urandom & 32'hFFFFFFFC;
			axi_wr(CTRL_ADDR, v, rsp);
			axi_rd(CTRL_ADDR, d, rsp);
			check(d, v & 32'h7F);
		end
		axi_wr(STATUS_ADDR, 32'hFFFFFFFF, rsp);
		check(rsp, RESP_OKAY);
		axi_rd(CTRL_ADDR, d, rsp);
		check(d, v & 32'h7F);
		$display("test registers done");
		ctrl(32'h0);
		@(negedge link_clk);
		{pw, pr, n, m} = {write_clk_out, recovered_clk_out, 64'h0};
		repeat (16) begin
			@(negedge link_clk);
			n += int'(write_clk_out !== pw);
			m += int'(recovered_clk_out !== pr);
			{pw, pr} = {write_clk_out, recovered_clk_out};
		end
		check(32'(n), 32'd16);
		check(32'(m), 32'd16);
		// Clock enable low freezes the link side as well
		@(posedge aclk);
		ce <= 1'b0;
		repeat (4) @(negedge link_clk);
		pw = write_clk_out;
		repeat (8) @(negedge link_clk);
		check({31'h0, write_clk_out}, {31'h0, pw});
		@(posedge aclk);
		ce <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			ctrl(32'(k) << 3);
			n = 0;
			repeat (12) begin
				@(negedge link_clk);
				n += int'(pfd_feed_out === 1'b1);
			end
			check(32'(n), 32'(pfd_exp(k[0], 12)));
		end
		$display("test clocks done");
		@(posedge link_clk);
		period <= 4'h2;
		watch(30);
		check({31'h0, sync_field_detect}, 32'h1);
		@(posedge link_clk);
		period <= 4'h8;
		watch(40);
		check({31'h0, sync_field_detect}, 32'h0);
		@(posedge link_clk);
		period <= 4'h2;
		watch(30);
		// Read gate raised without seek done
		{pulses, clamps} = 64'h0;
		ctrl(32'h01);
		watch(40);
		check(32'(pulses + clamps), 32'h0);
		$display("test detect done");
		{pulses, bad, clamps} = 96'h0;
		axi_wr(CTRL_ADDR, 32'h11, rsp);
		clamp_check();
		watch(VEL_CYC / 2);
		axi_rd(STATUS_ADDR, d, rsp);
		check(d & 32'hC, 32'h4);
		watch(VEL_CYC / 2 + 8);
		axi_rd(STATUS_ADDR, d, rsp);
		check(d & 32'hC, 32'h8);
		check(32'(bad), 32'h0);
		check(32'(pulses > 0), 32'h1);
		n = 0;
		@(posedge link_clk);
		period <= 4'h8;
		repeat (40) begin
			@(negedge link_clk);
			n += int'(pfd_feed_out !== 1'b1 || sync_field_detect !== 1'b1);
		end
		check(32'(n), 32'h0);
		axi_wr(CTRL_ADDR, 32'h10, rsp);
		clamp_check();
		$display("test read done");
		@(posedge link_clk);
		period <= 4'h0;
		ctrl(32'h16); // read gate kept low while writing
		wbit(1'b1, 1'b1, nom);
		check(32'(nom >= 0), 32'h1);
		wbit(1'b0, 1'b1, lat);
		check(32'(lat), 32'(nom - 1));
		wbit(1'b1, 1'b0, lat);
		check(32'(lat), 32'(nom + 1));
		wbit(1'b0, 1'b0, lat);
		check(32'(lat), 32'(nom - 1));
		ctrl(32'h12);
		wbit(1'b0, 1'b1, lat);
		check(32'(lat), 32'(nom));
		wbit(1'b1, 1'b0, lat);
		check(32'(lat), 32'(nom));
		ctrl(32'h10);
		wbit(1'b1, 1'b1, lat);
		check(32'(lat), 32'hFFFFFFFF);
		$display("test write done");
		results();
	end
endmodule
